// file: pwr_ctrl_pkg.sv
// constants, field layout and state type of the wait/stop power control
package pwr_ctrl_pkg;

   // ------------------------------------------------------------
   // wake source indices
   // ------------------------------------------------------------
   localparam int NUM_SRC = 15;
   localparam int SRC_SERIAL = 0;
   localparam int SRC_CSI_I2C = 1;
   localparam int SRC_KEY = 2;
   localparam int SRC_ADC = 3;
   localparam int SRC_ITMR = 4;
   localparam int SRC_TMR_B = 5;
   localparam int SRC_TMR_C = 6;
   localparam int SRC_CAL = 7;
   localparam int SRC_EXT0 = 8;
   localparam int SRC_EXT1 = 9;
   localparam int SRC_EXT3 = 10;
   localparam int SRC_EXT_OTHER = 11;
   localparam int SRC_VMON1 = 12;
   localparam int SRC_VMON2 = 13;
   localparam int SRC_OSC_FAIL = 14;
   localparam int PRIO_W = 3;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_WAKE_CFG = 8'h04;
   localparam logic [7:0] ADDR_PRIO_LO = 8'h08;
   localparam logic [7:0] ADDR_PRIO_HI = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;

   // ------------------------------------------------------------
   // control register fields
   // ------------------------------------------------------------
   localparam int CTRL_CLK_SRC = 0;
   localparam int CTRL_OSC_FAIL_IE = 1;
   localparam int CTRL_PCLK_HALT = 2;
   localparam int CTRL_FLASH_OFF = 3;
   localparam int CTRL_STOP = 4;
   localparam int CTRL_DIV_LSB = 5;
   localparam int CTRL_XCIN_DRV = 8;
   localparam int CTRL_XIN_DRV = 9;
   localparam int CTRL_W = 10;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h060;

   // ------------------------------------------------------------
   // wake configuration fields
   // ------------------------------------------------------------
   localparam int CFG_SERIAL_EXT = 0;
   localparam int CFG_ADC_ONE_SHOT = 1;
   localparam int CFG_ITMR_EVENT = 2;
   localparam int CFG_ITMR_FILT_OFF = 3;
   localparam int CFG_ITMR_SLOW_SRC = 4;
   localparam int CFG_CAL_RTC = 5;
   localparam int CFG_EXT0_FILT_OFF = 6;
   localparam int CFG_EXT1_FILT_OFF = 7;
   localparam int CFG_EXT3_FILT_OFF = 8;
   localparam int CFG_VMON1_FILT_DIS = 9;
   localparam int CFG_VMON2_FILT_DIS = 10;
   localparam int CFG_W = 11;
   localparam logic [CFG_W-1:0] CFG_RESET = 11'h000;

   // ------------------------------------------------------------
   // clock division codes and wake timing
   // ------------------------------------------------------------
   localparam logic [2:0] DIV_BY8 = 3'h3;
   localparam int CLK_PERIOD_PS = 10000;
   localparam int WAKE_FLASH_ON_NS = 60;
   localparam int WAKE_FLASH_OFF_NS = 400;
   localparam int TMR_W = 8;
   localparam logic [TMR_W-1:0] WAKE_CYC_FLASH_ON =
      TMR_W'((WAKE_FLASH_ON_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [TMR_W-1:0] WAKE_CYC_FLASH_OFF =
      TMR_W'((WAKE_FLASH_OFF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

   typedef enum logic [1:0] {PM_RUN, PM_WAIT, PM_STOP, PM_WAKE} pm_state_t;

endpackage : pwr_ctrl_pkg

// file: wake_qualifier.sv
// decides which pending interrupt requests may end wait or stop mode
`timescale 1ns/1ps
module wake_qualifier
   import pwr_ctrl_pkg::*;
(
   // requests and gating
   input wire logic [NUM_SRC-1:0] irq_req,
   input wire logic [PRIO_W*NUM_SRC-1:0] irq_priority_level,
   input wire logic irq_global_enable,
   // mode and configuration
   input wire logic in_wait,
   input wire logic in_stop,
   input wire logic periph_clock_halt_in_idle,
   input wire logic [CFG_W-1:0] cfg,
   // result
   output logic [NUM_SRC-1:0] qualified
);

   logic [NUM_SRC-1:0] wait_run_ok;
   logic [NUM_SRC-1:0] wait_halt_ok;
   logic [NUM_SRC-1:0] stop_ok;
   logic itmr_event_nf;

   // -------------------------------------------------------------
   // usability tables per mode
   // -------------------------------------------------------------
   always_comb begin
      itmr_event_nf = cfg[CFG_ITMR_EVENT] & cfg[CFG_ITMR_FILT_OFF];
      wait_run_ok = '1;
      wait_run_ok[SRC_ADC] = cfg[CFG_ADC_ONE_SHOT];
      // clocks halted, only externally or slowly clocked units
      wait_halt_ok = '0;
      wait_halt_ok[SRC_SERIAL] = cfg[CFG_SERIAL_EXT];
      wait_halt_ok[SRC_KEY] = 1'b1;
      // event count unfiltered or slow count source
      wait_halt_ok[SRC_ITMR] = itmr_event_nf | cfg[CFG_ITMR_SLOW_SRC];
      // calendar timer in real time clock mode
      wait_halt_ok[SRC_CAL] = cfg[CFG_CAL_RTC];
      // external inputs 0, 1, 3 unfiltered
      wait_halt_ok[SRC_EXT0] = cfg[CFG_EXT0_FILT_OFF];
      wait_halt_ok[SRC_EXT1] = cfg[CFG_EXT1_FILT_OFF];
      wait_halt_ok[SRC_EXT3] = cfg[CFG_EXT3_FILT_OFF];
      wait_halt_ok[SRC_VMON1] = 1'b1;
      wait_halt_ok[SRC_VMON2] = 1'b1;
      // stop keeps only externally clocked sources
      stop_ok = '0;
      // serial external clock, key, unfiltered external inputs
      stop_ok[SRC_SERIAL] = cfg[CFG_SERIAL_EXT];
      stop_ok[SRC_KEY] = 1'b1;
      stop_ok[SRC_EXT0] = cfg[CFG_EXT0_FILT_OFF];
      stop_ok[SRC_EXT1] = cfg[CFG_EXT1_FILT_OFF];
      stop_ok[SRC_EXT3] = cfg[CFG_EXT3_FILT_OFF];
      // interval timer counting external pulses unfiltered
      stop_ok[SRC_ITMR] = itmr_event_nf;
      // voltage monitors with digital filter disabled
      stop_ok[SRC_VMON1] = cfg[CFG_VMON1_FILT_DIS];
      stop_ok[SRC_VMON2] = cfg[CFG_VMON2_FILT_DIS];
   end

   // -------------------------------------------------------------
   // final gating by priority level and global enable
   // -------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < NUM_SRC; i++) begin
         qualified[i] = irq_req[i] & irq_global_enable
            & (irq_priority_level[PRIO_W*i +: PRIO_W] != '0)
            & ((in_wait & ~periph_clock_halt_in_idle & wait_run_ok[i])
            | (in_wait & periph_clock_halt_in_idle & wait_halt_ok[i])
            | (in_stop & stop_ok[i]));
      end
   end

endmodule : wake_qualifier

// file: wake_timer.sv
// down counter that times the restart from wake request to handler
`timescale 1ns/1ps
module wake_timer
   import pwr_ctrl_pkg::*;
#(
   parameter int W = TMR_W
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic start,
   input wire logic [W-1:0] load_value,
   // status
   output logic busy,
   output logic done
);

   typedef struct packed {
      logic [W-1:0] count;
      logic busy;
      logic done;
   } tmr_t;

   tmr_t r;
   tmr_t next_r;

   // -------------------------------------------------------------
   // count down, one-cycle done pulse at the end
   // -------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      if (start) begin
         next_r.count = load_value;
         next_r.busy = 1'b1;
      end else if (r.busy) begin
         if (r.count <= W'(1)) begin
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
         end else begin
            next_r.count = r.count - W'(1);
         end
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign busy = r.busy;
   assign done = r.done;

endmodule : wake_timer

// file: pwr_ctrl.sv
// wait and stop power control with wake qualification and APB registers
`timescale 1ns/1ps
module pwr_ctrl
   import pwr_ctrl_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // CPU side
   input wire logic halt_exec,
   input wire logic irq_global_enable,
   output logic irq_seq_start,
   output logic [3:0] wake_source,
   // peripheral interrupt requests
   input wire logic [NUM_SRC-1:0] irq_req,
   // clock and pin control
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic osc_run,
   output logic io_hold,
   output logic flash_pwr_down,
   output logic [2:0] cpu_div_sel,
   output logic system_clock_source_flag,
   output logic xin_drive_high,
   output logic xcin_drive_high
);

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   typedef struct packed {
      pm_state_t mode;
      logic [CTRL_W-1:0] ctrl;
      logic [CFG_W-1:0] cfg;
      logic [PRIO_W*NUM_SRC-1:0] prio;
      logic [2:0] saved_div;
      logic saved_src;
      logic from_wait;
      logic [3:0] src;
      logic tmr_start;
      logic seq;
      logic cpu_clk;
      logic [31:0] rdata;
      logic err;
   } pwr_t;

   pwr_t r;
   pwr_t next_r;

   logic [NUM_SRC-1:0] qualified;
   logic tmr_busy;
   logic tmr_done;
   logic access;
   logic setup;
   logic [TMR_W-1:0] wake_cycles;

   // lowest index of a set request
   function automatic logic [3:0] first_set(input logic [NUM_SRC-1:0] v);
      logic [3:0] idx;
      idx = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction : first_set

   // true when the offset is one of the mapped registers
   function automatic logic mapped(input logic [7:0] a);
      return (a == ADDR_CTRL) || (a == ADDR_WAKE_CFG)
         || (a == ADDR_PRIO_LO) || (a == ADDR_PRIO_HI)
         || (a == ADDR_STATUS);
   endfunction : mapped

   // -------------------------------------------------------------
   // wake qualification and restart timing
   // -------------------------------------------------------------
   wake_qualifier u_qual (
      .irq_req(irq_req),
      .irq_priority_level(r.prio),
      .irq_global_enable(irq_global_enable),
      .in_wait(r.mode == PM_WAIT),
      .in_stop(r.mode == PM_STOP),
      .periph_clock_halt_in_idle(r.ctrl[CTRL_PCLK_HALT]),
      .cfg(r.cfg),
      .qualified(qualified)
   );

   // restart time chosen by flash power-off bit
   assign wake_cycles = r.ctrl[CTRL_FLASH_OFF] ? WAKE_CYC_FLASH_OFF
                                               : WAKE_CYC_FLASH_ON;

   wake_timer #(
      .W(TMR_W)
   ) u_tmr (
      .pclk(pclk),
      .presetn(presetn),
      .start(r.tmr_start),
      .load_value(wake_cycles),
      .busy(tmr_busy),
      .done(tmr_done)
   );

   // bus phase decode
   assign setup = psel & ~penable;
   assign access = psel & penable;

   // -------------------------------------------------------------
   // next-state logic
   // -------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.tmr_start = 1'b0;
      next_r.seq = 1'b0;

      // register writes take effect at the access edge
      if (access && pwrite && r.mode == PM_RUN) begin
         case (paddr)
            ADDR_CTRL: begin
               next_r.ctrl = pwdata[CTRL_W-1:0];
               // stop request forces divide-by-8 and high drive
               if (pwdata[CTRL_STOP]) begin
                  next_r.ctrl[CTRL_DIV_LSB +: 3] = DIV_BY8;
                  next_r.ctrl[CTRL_XCIN_DRV] = 1'b1;
                  next_r.ctrl[CTRL_XIN_DRV] = 1'b1;
                  next_r.mode = PM_STOP;
                  next_r.from_wait = 1'b0;
                  next_r.cpu_clk = 1'b0;
               end
            end
            ADDR_WAKE_CFG: next_r.cfg = pwdata[CFG_W-1:0];
            ADDR_PRIO_LO: next_r.prio[23:0] = pwdata[23:0];
            ADDR_PRIO_HI: next_r.prio[PRIO_W*NUM_SRC-1:24] =
               pwdata[PRIO_W*NUM_SRC-25:0];
            default: begin
            end
         endcase
      end

      // read data is latched in the setup cycle
      if (setup) begin
         next_r.err = ~mapped(paddr);
         case (paddr)
            ADDR_CTRL: next_r.rdata = 32'(r.ctrl);
            ADDR_WAKE_CFG: next_r.rdata = 32'(r.cfg);
            ADDR_PRIO_LO: next_r.rdata = {8'h00, r.prio[23:0]};
            ADDR_PRIO_HI: next_r.rdata =
               32'(r.prio[PRIO_W*NUM_SRC-1:24]);
            ADDR_STATUS: next_r.rdata = {22'h00_0000, r.from_wait,
               r.saved_div, r.src, r.mode};
            default: next_r.rdata = 32'h0000_0000;
         endcase
      end

      // power mode sequencing
      case (r.mode)
         PM_RUN: begin
            if (halt_exec && next_r.mode == PM_RUN) begin
               next_r.mode = PM_WAIT;
               next_r.from_wait = 1'b1;
               // capture clock source and division at halt
               next_r.saved_div = r.ctrl[CTRL_DIV_LSB +: 3];
               next_r.saved_src = r.ctrl[CTRL_CLK_SRC];
               // oscillation-fail enable keeps CPU clock on
               next_r.cpu_clk = r.ctrl[CTRL_OSC_FAIL_IE];
            end
         end
         PM_WAIT, PM_STOP: begin
            // only a qualified interrupt ends the low-power mode
            if (qualified != '0) begin
               // capture request, restart clock, then time the entry
               next_r.src = first_set(qualified);
               next_r.mode = PM_WAKE;
               next_r.cpu_clk = 1'b1;
               next_r.tmr_start = 1'b1;
            end
         end
         PM_WAKE: begin
            if (tmr_done) begin
               next_r.mode = PM_RUN;
               next_r.seq = 1'b1;
               next_r.ctrl[CTRL_STOP] = 1'b0;
               // restore source and division after wait
               if (r.from_wait) begin
                  next_r.ctrl[CTRL_DIV_LSB +: 3] = r.saved_div;
                  next_r.ctrl[CTRL_CLK_SRC] = r.saved_src;
               end
            end
         end
         default: begin
            next_r.mode = PM_RUN;
            next_r.cpu_clk = 1'b1;
         end
      endcase
   end

   // -------------------------------------------------------------
   // state register
   // -------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r.mode <= PM_RUN;
         r.ctrl <= CTRL_RESET;
         r.cfg <= CFG_RESET;
         r.prio <= '0;
         r.saved_div <= DIV_BY8;
         r.saved_src <= 1'b0;
         r.from_wait <= 1'b0;
         r.src <= '0;
         r.tmr_start <= 1'b0;
         r.seq <= 1'b0;
         r.cpu_clk <= 1'b1;
         r.rdata <= 32'h0000_0000;
         r.err <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   // bus answers in the first access cycle
   assign pready = 1'b1;
   assign pslverr = access & r.err;
   assign prdata = r.rdata;

   // CPU handshake
   assign irq_seq_start = r.seq;
   assign wake_source = r.src;

   // glitch-free CPU clock gate from a flop
   assign cpu_clk_en = r.cpu_clk;
   // peripheral clocks stop in wait only when asked
   assign periph_clk_en = (r.mode == PM_RUN) || (r.mode == PM_WAKE)
      || (r.mode == PM_WAIT && !r.ctrl[CTRL_PCLK_HALT]);
   assign osc_run = (r.mode != PM_STOP);
   // ports frozen while the CPU is idle
   assign io_hold = (r.mode == PM_WAIT) || (r.mode == PM_STOP);
   assign flash_pwr_down = io_hold & r.ctrl[CTRL_FLASH_OFF];
   assign cpu_div_sel = r.ctrl[CTRL_DIV_LSB +: 3];
   assign system_clock_source_flag = r.ctrl[CTRL_CLK_SRC];
   assign xin_drive_high = r.ctrl[CTRL_XIN_DRV];
   assign xcin_drive_high = r.ctrl[CTRL_XCIN_DRV];

endmodule : pwr_ctrl

// file: pwr_ctrl_chk.sv
// assertion checker for the wait and stop power control
`timescale 1ns/1ps
module pwr_ctrl_chk
   import pwr_ctrl_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // cpu and requests
   input wire logic halt_exec,
   input wire logic irq_seq_start,
   input wire logic [3:0] wake_source,
   input wire logic [NUM_SRC-1:0] irq_req,
   // clock and pin control
   input wire logic cpu_clk_en,
   input wire logic periph_clk_en,
   input wire logic osc_run,
   input wire logic io_hold,
   input wire logic flash_pwr_down,
   input wire logic [2:0] cpu_div_sel,
   input wire logic xin_drive_high,
   input wire logic xcin_drive_high
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [NUM_SRC-1:0] req_q;
   logic hold_q;
   logic [2:0] div_q;
   logic [2:0] saved_div;
   logic saved_wait;
   // remembers requests and the divider in use before mode entry
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_q <= '0;
         hold_q <= 1'b0;
         div_q <= 3'h0;
         saved_div <= 3'h0;
         saved_wait <= 1'b0;
      end else begin
         req_q <= irq_req;
         hold_q <= io_hold;
         div_q <= cpu_div_sel;
         if (io_hold && !hold_q) begin
            saved_div <= div_q;
            saved_wait <= osc_run;
         end
      end
   end
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   AST_WAIT_ENTRY: assert property ($rose(io_hold) && osc_run |->
      $past(halt_exec)) else $error("wait entered without halt");
   AST_STOP_CLOCKS: assert property (!osc_run |->
      !cpu_clk_en && !periph_clk_en && io_hold)
      else $error("clock running in stop");
   AST_CLK_OFF_HOLD: assert property (!cpu_clk_en |-> io_hold)
      else $error("cpu clock off while pins free");
   AST_WAKE_CAUSE: assert property ($fell(io_hold) |->
      req_q[wake_source]) else $error("wake without request");
   AST_WAKE_CLK: assert property ($fell(io_hold) |->
      cpu_clk_en && !irq_seq_start) else $error("wake clock order");
   AST_LAT_FAST: assert property ($fell(io_hold) &&
      !$past(flash_pwr_down) |-> ##1 !irq_seq_start[*7] ##1 irq_seq_start)
      else $error("short wake latency wrong");
   AST_LAT_SLOW: assert property ($fell(io_hold) &&
      $past(flash_pwr_down) |-> ##42 irq_seq_start)
      else $error("long wake latency wrong");
   AST_STOP_FORCE: assert property ($fell(osc_run) |->
      cpu_div_sel == DIV_BY8 && xin_drive_high && xcin_drive_high)
      else $error("stop entry forcing missing");
   AST_RESUME_DIV: assert property (irq_seq_start && saved_wait |=>
      cpu_div_sel == saved_div) else $error("divider not restored");
   // main scenarios
   cover property ($fell(io_hold) && osc_run);
   cover property ($rose(osc_run));
   cover property ($rose(io_hold) && cpu_clk_en);
endmodule : pwr_ctrl_chk

bind pwr_ctrl pwr_ctrl_chk chk (.pclk, .presetn, .halt_exec,
   .irq_seq_start, .wake_source, .irq_req, .cpu_clk_en, .periph_clk_en,
   .osc_run, .io_hold, .flash_pwr_down, .cpu_div_sel, .xin_drive_high,
   .xcin_drive_high);

// file: cpu_irq_model.sv
// cpu and peripheral request model facing the power control
`timescale 1ns/1ps
module cpu_irq_model
   import pwr_ctrl_pkg::*;
(
   // clock, reset and bench commands
   input wire logic pclk,
   input wire logic presetn,
   input wire logic halt_cmd,
   input wire logic gie_cmd,
   input wire logic [NUM_SRC-1:0] raise_cmd,
   // power control side
   input wire logic irq_seq_start,
   output logic halt_exec,
   output logic irq_global_enable,
   output logic [NUM_SRC-1:0] irq_req
);
   // enable flag, requests held until handled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_exec <= 1'b0;
         irq_global_enable <= 1'b0;
         irq_req <= '0;
      end else begin
         halt_exec <= halt_cmd;
         irq_global_enable <= gie_cmd;
         if (irq_seq_start) begin
            irq_req <= '0;
         end else begin
            irq_req <= irq_req | raise_cmd;
         end
      end
   end
endmodule : cpu_irq_model

// file: pwr_ctrl_tb_top.sv
// self-checking bench for the wait and stop power control
`timescale 1ns/1ps
module pwr_ctrl_tb_top
   import pwr_ctrl_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic halt_cmd = 1'b0;
   logic gie_cmd = 1'b1;
   logic [NUM_SRC-1:0] raise_cmd = '0;
   logic [31:0] ctrl_base = 32'h0000_0020;
   logic [31:0] prdata;
   logic [31:0] rd_q;
   logic pready, pslverr, err_q, halt_exec, irq_global_enable;
   logic irq_seq_start, cpu_clk_en, periph_clk_en, osc_run, io_hold;
   logic flash_pwr_down, system_clock_source_flag;
   logic xin_drive_high, xcin_drive_high;
   logic [3:0] wake_source;
   logic [2:0] cpu_div_sel;
   logic [NUM_SRC-1:0] irq_req;
   int mismatches = 0;
   int total_checks = 0;
   // case word: mode, source, wake expected, wake configuration
   localparam logic [23:0] CASES [0:32] = '{
      24'h02_1000, 24'h41_1000, 24'h8E_1000, 24'h03_0000, 24'h03_1002,
      24'h13_0002, 24'h11_0000, 24'h10_0000, 24'h10_1001, 24'h14_0004,
      24'h14_100C, 24'h14_1010, 24'h17_1020, 24'h17_0000, 24'h18_1040,
      24'h19_1080, 24'h1A_1100, 24'h1A_0000, 24'h1B_01C0, 24'h15_0000,
      24'h1E_0000, 24'h12_1000, 24'h1C_1000, 24'h22_1000, 24'h24_100C,
      24'h24_0010, 24'h20_1001, 24'h20_0000, 24'h2C_1200, 24'h2C_0000,
      24'h2D_1400, 24'h28_1040, 24'h27_0020};

   pwr_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .halt_exec(halt_exec), .irq_global_enable(irq_global_enable),
      .irq_seq_start(irq_seq_start), .wake_source(wake_source),
      .irq_req(irq_req), .cpu_clk_en(cpu_clk_en),
      .periph_clk_en(periph_clk_en), .osc_run(osc_run), .io_hold(io_hold),
      .flash_pwr_down(flash_pwr_down), .cpu_div_sel(cpu_div_sel),
      .system_clock_source_flag(system_clock_source_flag),
      .xin_drive_high(xin_drive_high), .xcin_drive_high(xcin_drive_high));
   cpu_irq_model cpu (.pclk(pclk), .presetn(presetn), .halt_cmd(halt_cmd),
      .gie_cmd(gie_cmd), .raise_cmd(raise_cmd),
      .irq_seq_start(irq_seq_start), .halt_exec(halt_exec),
      .irq_global_enable(irq_global_enable), .irq_req(irq_req));

   // clock and bus answer capture before each edge lands
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      rd_q <= prdata;
      err_q <= pslverr;
   end

   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
         input logic err);
      apb(1'b0, a, 32'h0000_0000);
      chk($sformatf("data %h", a), exp, rd_q);
      chk($sformatf("error %h", a), {31'h0, err}, {31'h0, err_q});
   endtask : rd

   task automatic setup_prio();
      apb(1'b1, ADDR_PRIO_LO, 32'h0024_9249);
      apb(1'b1, ADDR_PRIO_HI, 32'h0004_9249);
   endtask : setup_prio

   task automatic run_case(input logic [23:0] c);
      logic [3:0] m;
      int n;
      m = c[23:20];
      apb(1'b1, ADDR_WAKE_CFG, {20'h0_0000, c[11:0]});
      // osc-fail enable only with source flag clear
      apb(1'b1, ADDR_CTRL, {27'h0, m[1], m[2], m[0], m[3], 1'b0} | ctrl_base);
      if (!m[1]) begin
         @(posedge pclk);
         halt_cmd <= 1'b1;
         @(posedge pclk);
         halt_cmd <= 1'b0;
      end
      repeat (3) @(posedge pclk);
      #1;
      chk("hold", 1, io_hold);
      chk("cpu clock", m[3], cpu_clk_en);
      chk("periph clock", !(m[0] | m[1]), periph_clk_en);
      chk("osc", !m[1], osc_run);
      chk("flash", m[2], flash_pwr_down);
      chk("force", {xin_drive_high, xcin_drive_high, cpu_div_sel},
         m[1] ? {2'b11, DIV_BY8}
         : {2'b00, ctrl_base[CTRL_DIV_LSB +: 3]});
      @(posedge pclk);
      raise_cmd[c[19:16]] <= 1'b1;
      @(posedge pclk);
      raise_cmd <= '0;
      n = 0;
      do begin
         @(posedge pclk);
         #1;
         n++;
      end while (io_hold === 1'b1 && n < 12);
      chk($sformatf("wake %h", c), c[12], !io_hold);
      if (c[12]) begin
         chk("source", c[19:16], wake_source);
         n = 0;
         do begin
            @(posedge pclk);
            #1;
            n++;
         end while (irq_seq_start !== 1'b1 && n < 50);
         chk("latency", m[2] ? 42 : 8, n);
         chk("div", m[1] ? DIV_BY8 : ctrl_base[CTRL_DIV_LSB +: 3],
            cpu_div_sel);
         chk("source flag", ctrl_base[CTRL_CLK_SRC],
            system_clock_source_flag);
      end else begin
         @(posedge pclk);
         presetn <= 1'b0;
         @(posedge pclk);
         presetn <= 1'b1;
         #1;
         chk("hold after reset", 0, io_hold);
         setup_prio();
      end
   endtask : run_case

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : give_verdict

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_CTRL, 32'h0000_0060, 1'b0);
      rd(ADDR_WAKE_CFG, 32'h0000_0000, 1'b0);
      rd(ADDR_PRIO_HI, 32'h0000_0000, 1'b0);
      rd(8'h14, 32'h0000_0000, 1'b1);
      apb(1'b1, 8'h14, 32'hFFFF_FFFF);
      chk("write error", 1, err_q);
      setup_prio();
      rd(ADDR_PRIO_LO, 32'h0024_9249, 1'b0);
      apb(1'b1, ADDR_PRIO_LO, 32'h0024_9009);
      run_case(24'h02_0000);
      gie_cmd <= 1'b0;
      run_case(24'h02_0000);
      gie_cmd <= 1'b1;
      // on-chip source, no division kept across wait
      ctrl_base = 32'h0000_0001;
      run_case(24'h02_1000);
      rd(ADDR_STATUS, 32'h0000_0208, 1'b0);
      ctrl_base = 32'h0000_0020;
      for (int i = 0; i < 33; i++) begin
         run_case(CASES[i]);
      end
      give_verdict();
   end
   initial begin
      #400_000;
      mismatches++;
      give_verdict();
   end
endmodule : pwr_ctrl_tb_top
